// file: pkg/dcnc_pkg.sv
// Constants, register map and state codes of the converter control core.
// Assumes a single 100 MHz system clock domain.
// Operation
// R1: Output code is unsigned straight binary
// R2: Any reset loads all registers from NVM
// R3: Code width is 8 or 10 bits
// R4: Supply reference by default; bit enables internal
// R5: Two-bit field selects 1.5x to 4x gain
// R6: New code applies when write frame ends
// R7: Update-busy flag high while waveform runs
// R8: Host avoids converter writes while update-busy
// R9: Store bit saves settings to NVM
// R10: Memory_op_active flag set, writes ignored meanwhile
// R11: Host avoids code reads while Memory_op_active
// R12: Recall bit reloads NVM, then self-clears
// R13: Configuration fields at fixed bit positions
// R14: Output code in bits 11:2, NVM-backed
// R15: Margin codes in bits 11:4, NVM-backed
// R16: Waveform start bit 8 is NVM-backed
// R17: 10-bit CRC stored and checked with NVM
// R18: Two CRC fault flags in status
// R19: User CRC fault loads factory values
// R20: Internal CRC fault loads factory values
// R21: Fault flags clear only by reset
// R22: Output powers up high-impedance unless saved
// R23: Code 1010 in reset field restarts device
// R24: NVM write keeps busy for 10 ms
// R25: CRC polynomial 0x233, MSB first, zero seed
package dcnc_pkg;
  localparam int          CLK_MHZ      = 100;
  localparam int          PROG_TIME_US = 10000;
  localparam int          PROG_CYC     = PROG_TIME_US * CLK_MHZ;
  localparam int          LOAD_CYC     = 16;
  localparam logic [7:0]  REG_CODE     = 8'h10;
  localparam logic [7:0]  REG_MHI      = 8'h25;
  localparam logic [7:0]  REG_MLO      = 8'h26;
  localparam logic [7:0]  REG_STAT     = 8'hD0;
  localparam logic [7:0]  REG_CFG      = 8'hD1;
  localparam logic [7:0]  REG_TRIG     = 8'hD3;
  localparam int          TRIG_GO      = 8;
  localparam int          TRIG_RCL     = 5;
  localparam int          TRIG_STO     = 4;
  localparam logic [3:0]  SRST_CODE    = 4'hA;
  localparam int          CFG_WAVE_LSB = 14;
  localparam int          CFG_PDN_LSB  = 3;
  localparam int          CFG_REF      = 2;
  localparam int          CFG_SPAN_LSB = 0;
  localparam int          CODE_MSB     = 11;
  localparam logic [15:0] CFG_MASK     = 16'hEFFF;
  localparam logic [15:0] MARGIN_MASK  = 16'h0FF0;
  localparam logic [15:0] CFG_RST      = 16'h01F0;
  localparam logic [15:0] CODE_RST     = 16'h0000;
  localparam logic [15:0] MARGIN_RST   = 16'h0000;
  localparam logic        GO_RST       = 1'b0;
  localparam logic [1:0]  PDN_HIZ      = 2'b10;
  localparam int          IMG_W        = 65;
  localparam int          TRIM_W       = 16;
  localparam logic [9:0]  CRC_POLY     = 10'h233;
  localparam logic [IMG_W-1:0] IMG_RST =
    {CFG_RST, GO_RST, CODE_RST, MARGIN_RST, MARGIN_RST};

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_PROG = 2'b10
  } dcnc_state_e;
endpackage

// file: hdl/dcnc_twi.sv
// Two-wire serial slave: pointer byte, then 16-bit data MSB first.
// Assumes scl_in and sda_in are raw pins; sampled with clk_sys.
`timescale 1ns/100ps
module dcnc_twi
#(
  parameter logic [6:0] DEV_ADDR = 7'h48
)
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  output logic             wr_stb,
  output logic [7:0]       reg_ptr,
  output logic [15:0]      wr_data,
  input  wire logic [15:0] rd_data
);
  typedef struct packed {
    logic [2:0]  sc;
    logic [2:0]  sd;
    logic        act;
    logic        rw;
    logic        ackp;
    logic        pend;
    logic        tsel;
    logic        oe;
    logic        wr;
    logic [3:0]  bc;
    logic [1:0]  bn;
    logic [7:0]  sh;
    logic [7:0]  ptr;
    logic [15:0] wd;
  } dcnc_twi_s;

  dcnc_twi_s s;
  dcnc_twi_s next_s;
  logic      rise;
  logic      fall;
  logic      start;
  logic      stop;

  // Stage 0 feeds only stage 1; edges use stages 1 and 2
  assign rise  = s.sc[1] & ~s.sc[2];
  assign fall  = ~s.sc[1] & s.sc[2];
  assign start = s.sc[1] & s.sc[2] & s.sd[2] & ~s.sd[1];
  assign stop  = s.sc[1] & s.sc[2] & ~s.sd[2] & s.sd[1];

  always_comb
  begin
    next_s    = s;
    next_s.sc = {s.sc[1:0], scl_in};
    next_s.sd = {s.sd[1:0], sda_in};
    next_s.wr = 1'b0;
    if (start)
    begin
      next_s.act  = 1'b1;
      next_s.rw   = 1'b0;
      next_s.ackp = 1'b0;
      next_s.pend = 1'b0;
      next_s.oe   = 1'b0;
      next_s.bc   = 4'h0;
      next_s.bn   = 2'h0;
    end
    else if (stop)
    begin
      // Data commits only at frame end
      next_s.wr   = s.pend; // R6
      next_s.pend = 1'b0;
      next_s.act  = 1'b0;
      next_s.oe   = 1'b0;
    end
    else if (s.act && rise)
    begin
      if (s.bc != 4'h8)
      begin
        next_s.bc = s.bc + 4'h1;
        if (!s.rw)
          next_s.sh = {s.sh[6:0], s.sd[1]};
      end
      else if (s.rw && !s.ackp)
      begin
        // Host NACK ends the read; ACK asks for the next byte
        if (s.sd[1])
          next_s.act = 1'b0;
        else
          next_s.ackp = 1'b1;
      end
    end
    else if (s.act && fall)
    begin
      if (s.ackp)
      begin
        next_s.ackp = 1'b0;
        next_s.bc   = 4'h0;
        next_s.oe   = 1'b0;
        if (s.rw)
        begin
          next_s.sh   = s.tsel ? rd_data[7:0] : rd_data[15:8];
          next_s.tsel = ~s.tsel;
          next_s.oe   = ~next_s.sh[7];
        end
      end
      else if (s.bc == 4'h8 && !s.rw)
      begin
        next_s.ackp = 1'b1;
        next_s.oe   = 1'b1;
        next_s.bn   = (s.bn == 2'h3) ? 2'h3 : s.bn + 2'h1;
        unique case (s.bn)
          2'h0:
            if (s.sh[7:1] != DEV_ADDR)
            begin
              next_s.act  = 1'b0;
              next_s.ackp = 1'b0;
              next_s.oe   = 1'b0;
            end
            else
            begin
              next_s.rw   = s.sh[0];
              next_s.tsel = 1'b0;
            end
          2'h1: next_s.ptr = s.sh;
          2'h2: next_s.wd[15:8] = s.sh;
          2'h3:
          begin
            next_s.wd[7:0] = s.sh;
            next_s.pend    = 1'b1;
          end
        endcase
      end
      else if (s.bc == 4'h8)
        next_s.oe = 1'b0;
      else if (s.rw && s.bc != 4'h0)
      begin
        next_s.sh = {s.sh[6:0], 1'b0};
        next_s.oe = ~next_s.sh[7];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      s <= '{sc: 3'h7, sd: 3'h7, default: '0};
    else
      s <= next_s;
  end

  // Open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe  = s.oe;
  assign wr_stb  = s.wr;
  assign reg_ptr = s.ptr;
  assign wr_data = s.wd;
endmodule

// file: hdl/dcnc_nvm.sv
// Nonvolatile image model in flip-flops with CRC check of each image.
// Assumes rst_nvm_n models factory programming, kept apart from rst_n.
`timescale 1ns/100ps
module dcnc_nvm
#(
  parameter logic [15:0] TRIM = 16'h5A3C // Arbitrary factory trim
)
(
  input  wire logic                       clk_sys,
  input  wire logic                       rst_nvm_n,
  input  wire logic                       prog,
  input  wire logic [dcnc_pkg::IMG_W-1:0] prog_data,
  input  wire logic                       corrupt_user,
  input  wire logic                       corrupt_trim,
  output logic [dcnc_pkg::IMG_W-1:0]      user_data,
  output logic                            user_ok,
  output logic                            trim_ok
);
  localparam int W = dcnc_pkg::IMG_W;

  function automatic logic [9:0] crc_of(input logic [W-1:0] d,
                                        input int n);
    logic [9:0] c;
    logic       fb;
    c = 10'h000; // R25
    for (int i = W - 1; i >= 0; i--)
    begin
      fb = c[9] ^ d[i];
      if (i < n)
        c = {c[8:0], 1'b0} ^ (fb ? dcnc_pkg::CRC_POLY : 10'h000); // R25
    end
    return c;
  endfunction

  typedef struct packed {
    logic [W-1:0]               ud;
    logic [9:0]                 uc;
    logic [dcnc_pkg::TRIM_W-1:0] td;
    logic [9:0]                 tc;
  } dcnc_nvm_s;

  localparam logic [W-1:0] TRIM_EXT = W'(TRIM);
  localparam dcnc_nvm_s RST_S = '{
    ud: dcnc_pkg::IMG_RST,
    uc: crc_of(dcnc_pkg::IMG_RST, W),
    td: TRIM,
    tc: crc_of(TRIM_EXT, dcnc_pkg::TRIM_W)
  };

  dcnc_nvm_s s;
  dcnc_nvm_s next_s;

  always_comb
  begin
    next_s = s;
    if (prog)
    begin
      next_s.ud = prog_data;
      next_s.uc = crc_of(prog_data, W); // R17
    end
    // Single-bit upsets for exercising the alarm path
    if (corrupt_user)
      next_s.ud[0] = ~s.ud[0];
    if (corrupt_trim)
      next_s.td[0] = ~s.td[0];
  end

  always_ff @(posedge clk_sys or negedge rst_nvm_n)
  begin
    if (!rst_nvm_n)
      s <= RST_S;
    else
      s <= next_s;
  end

  assign user_data = s.ud;
  assign user_ok   = crc_of(s.ud, W) == s.uc; // R17
  assign trim_ok   = crc_of(W'(s.td), dcnc_pkg::TRIM_W) == s.tc; // R17
endmodule

// file: hdl/dcnc_core.sv
// Converter control core: registers, NVM store and recall, CRC alarms.
// Assumes a two-wire host on the pins and one 100 MHz clock.
`timescale 1ns/100ps
module dcnc_core
#(
  parameter int         RES      = 10,
  parameter logic [6:0] DEV_ADDR = 7'h48,
  parameter int         PROG_CYC = dcnc_pkg::PROG_CYC
)
(
  input  wire logic           clk_sys,
  input  wire logic           rst_n,
  input  wire logic           rst_nvm_n,
  input  wire logic           scl_in,
  input  wire logic           sda_in,
  output logic                sda_out,
  output logic                sda_oe,
  input  wire logic           corrupt_user,
  input  wire logic           corrupt_trim,
  output logic [RES-1:0]      dac_code,
  output logic                ref_enable,
  output logic [1:0]          gain_select,
  output logic                out_hiz,
  output logic                out_load_10k,
  output logic [1:0]          waveform_select,
  output logic                waveform_go,
  output logic                update_busy,
  output logic                memory_op_active,
  output logic                user_crc_fault,
  output logic                factory_crc_fault
);
  localparam int TMAX =
    PROG_CYC > dcnc_pkg::LOAD_CYC ? PROG_CYC : dcnc_pkg::LOAD_CYC;
  localparam int TW = $clog2(TMAX + 1);
  localparam logic [TW-1:0] PROG_END = TW'(PROG_CYC - 1);
  localparam logic [TW-1:0] LOAD_END = TW'(dcnc_pkg::LOAD_CYC - 1);
  localparam logic [15:0] CODE_MASK =
    16'(((1 << RES) - 1) << (dcnc_pkg::CODE_MSB + 1 - RES)); // R3

  typedef struct packed {
    dcnc_pkg::dcnc_state_e st;
    logic [TW-1:0]         tmr;
    logic [15:0]           cfg;
    logic [15:0]           code;
    logic [15:0]           mhi;
    logic [15:0]           mlo;
    logic                  go;
    logic                  sto;
    logic                  rcl;
    logic                  ufl;
    logic                  ffl;
    logic                  prog;
  } dcnc_ctl_s;

  // Reset enters the load state so every start recalls the NVM image
  localparam dcnc_ctl_s RST_S = '{
    st:   dcnc_pkg::ST_LOAD,
    tmr:  '0,
    cfg:  dcnc_pkg::CFG_RST,
    code: dcnc_pkg::CODE_RST,
    mhi:  dcnc_pkg::MARGIN_RST,
    mlo:  dcnc_pkg::MARGIN_RST,
    go:   dcnc_pkg::GO_RST,
    default: '0
  };

  dcnc_ctl_s                  s;
  dcnc_ctl_s                  next_s;
  logic                       wr_stb;
  logic [7:0]                 reg_ptr;
  logic [15:0]                wr_data;
  logic [15:0]                rd_data;
  logic [dcnc_pkg::IMG_W-1:0] nvm_data;
  logic                       user_ok;
  logic                       trim_ok;
  logic                       busy;
  logic                       swrst;
  logic                       load_end;

  dcnc_twi
  #(
    .DEV_ADDR (DEV_ADDR)
  )
  u_twi
  (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .sda_out (sda_out),
    .sda_oe  (sda_oe),
    .wr_stb  (wr_stb),
    .reg_ptr (reg_ptr),
    .wr_data (wr_data),
    .rd_data (rd_data)
  );

  dcnc_nvm u_nvm
  (
    .clk_sys      (clk_sys),
    .rst_nvm_n    (rst_nvm_n),
    .prog         (s.prog),
    .prog_data    ({s.cfg, s.go, s.code, s.mhi, s.mlo}), // R16
    .corrupt_user (corrupt_user),
    .corrupt_trim (corrupt_trim),
    .user_data    (nvm_data),
    .user_ok      (user_ok),
    .trim_ok      (trim_ok)
  );

  assign busy     = s.st != dcnc_pkg::ST_IDLE;
  assign load_end = s.st == dcnc_pkg::ST_LOAD && s.tmr == LOAD_END;
  assign swrst    = wr_stb && !busy && reg_ptr == dcnc_pkg::REG_TRIG
                    && wr_data[3:0] == dcnc_pkg::SRST_CODE; // R23

  // Read mux; unmapped pointers read zero
  always_comb
  begin
    unique case (reg_ptr)
      dcnc_pkg::REG_CODE: rd_data = s.code;
      dcnc_pkg::REG_MHI:  rd_data = s.mhi;
      dcnc_pkg::REG_MLO:  rd_data = s.mlo;
      dcnc_pkg::REG_CFG:  rd_data = s.cfg;
      dcnc_pkg::REG_STAT:
        rd_data = {s.ufl, s.ffl, busy, s.go, 12'h000}; // R18
      dcnc_pkg::REG_TRIG:
        rd_data = {7'h00, s.go, 2'b00, s.rcl, s.sto, 4'h0};
      default:            rd_data = 16'h0000;
    endcase
  end

  always_comb
  begin
    next_s      = s;
    next_s.prog = 1'b0;
    unique case (s.st)
      dcnc_pkg::ST_IDLE:
        // Writes during NVM activity never reach this branch
        if (wr_stb) // R10
        begin
          unique case (reg_ptr)
            dcnc_pkg::REG_CODE:
              next_s.code = wr_data & CODE_MASK; // R1 R14
            dcnc_pkg::REG_MHI:
              next_s.mhi = wr_data & dcnc_pkg::MARGIN_MASK; // R15
            dcnc_pkg::REG_MLO:
              next_s.mlo = wr_data & dcnc_pkg::MARGIN_MASK; // R15
            dcnc_pkg::REG_CFG:
              next_s.cfg = wr_data & dcnc_pkg::CFG_MASK; // R13
            dcnc_pkg::REG_TRIG:
              if (swrst)
                next_s = RST_S; // R23 R21
              else
              begin
                next_s.go = wr_data[dcnc_pkg::TRIG_GO];
                if (wr_data[dcnc_pkg::TRIG_STO])
                begin
                  next_s.st   = dcnc_pkg::ST_PROG; // R9
                  next_s.sto  = 1'b1;
                  next_s.prog = 1'b1;
                  next_s.tmr  = '0;
                end
                else if (wr_data[dcnc_pkg::TRIG_RCL])
                begin
                  next_s.st  = dcnc_pkg::ST_LOAD; // R12
                  next_s.rcl = 1'b1;
                  next_s.tmr = '0;
                end
              end
            default: ;
          endcase
        end
      dcnc_pkg::ST_LOAD:
      begin
        next_s.tmr = s.tmr + 1'b1;
        if (load_end)
        begin
          next_s.st  = dcnc_pkg::ST_IDLE;
          next_s.tmr = '0;
          next_s.rcl = 1'b0; // R12
          if (user_ok && trim_ok)
            {next_s.cfg, next_s.go, next_s.code, next_s.mhi,
             next_s.mlo} = nvm_data; // R2
          else
            {next_s.cfg, next_s.go, next_s.code, next_s.mhi,
             next_s.mlo} = dcnc_pkg::IMG_RST; // R19 R20
          // Sticky: only a reset clears them
          next_s.ufl = s.ufl | ~user_ok; // R18 R19 R21
          next_s.ffl = s.ffl | ~trim_ok; // R18 R20 R21
        end
      end
      dcnc_pkg::ST_PROG:
      begin
        next_s.tmr = s.tmr + 1'b1;
        if (s.tmr == PROG_END) // R24
        begin
          next_s.st  = dcnc_pkg::ST_IDLE;
          next_s.tmr = '0;
          next_s.sto = 1'b0;
        end
      end
      default: next_s = RST_S;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      s <= RST_S; // R2
    else
      s <= next_s;
  end

  // Code leaves the register untouched; straight binary out
  assign dac_code = s.code[dcnc_pkg::CODE_MSB -: RES]; // R1 R3
  assign ref_enable  = s.cfg[dcnc_pkg::CFG_REF]; // R4
  // Gain only matters while the internal reference is on
  assign gain_select = s.cfg[dcnc_pkg::CFG_SPAN_LSB +: 2]; // R5
  assign out_hiz = s.cfg[dcnc_pkg::CFG_PDN_LSB +: 2]
                   == dcnc_pkg::PDN_HIZ; // R22
  assign out_load_10k = s.cfg[dcnc_pkg::CFG_PDN_LSB]; // R22
  assign waveform_select = s.cfg[dcnc_pkg::CFG_WAVE_LSB +: 2];
  assign waveform_go = s.go;
  // Waveform runs until software stops it; busy follows the run
  assign update_busy = s.go; // R7
  assign memory_op_active = busy; // R10
  assign user_crc_fault = s.ufl;
  assign factory_crc_fault = s.ffl;

  default clocking dcb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  a_code_at_end: assert property ( // R6
    $changed(s.code) |-> $past(wr_stb) || $past(s.st) != dcnc_pkg::ST_IDLE
  ) else $error("Code changed outside a frame end or load");

  a_write_blocked: assert property ( // R10
    // A load ending in the same cycle may legally change both
    (wr_stb && busy && !load_end) |=> $stable(s.code) && $stable(s.cfg)
  ) else $error("Register write taken while Memory_op_active");

  a_prog_holds: assert property ( // R24
    $rose(s.st == dcnc_pkg::ST_PROG) |-> memory_op_active [*8]
  ) else $error("Memory_op_active dropped early in programming");

  a_prog_ends: assert property ( // R9
    (s.st == dcnc_pkg::ST_PROG && s.tmr == PROG_END)
      |=> s.st == dcnc_pkg::ST_IDLE && !s.sto
  ) else $error("Programming did not end on its count");

  a_recall_clear: assert property ( // R12
    load_end |=> !s.rcl && !memory_op_active
  ) else $error("Recall bit not cleared after load");

  a_fault_sticky: assert property ( // R21
    ($fell(s.ufl) || $fell(s.ffl)) |-> $past(swrst)
  ) else $error("CRC fault cleared without reset");

  a_crc_defaults: assert property ( // R19
    (load_end && !(user_ok && trim_ok))
      |=> s.cfg == dcnc_pkg::CFG_RST && s.code == dcnc_pkg::CODE_RST
          && (s.ufl || s.ffl)
  ) else $error("CRC failure did not load factory values");

  a_soft_reset: assert property ( // R23
    swrst |=> s.st == dcnc_pkg::ST_LOAD && !s.ufl && !s.ffl
  ) else $error("Soft reset did not restart the load");

  a_busy_cause: assert property ( // R7
    $rose(update_busy) |-> $past(wr_stb && reg_ptr == dcnc_pkg::REG_TRIG)
                           || $past(s.st) == dcnc_pkg::ST_LOAD
  ) else $error("Update busy rose without a cause");
endmodule

// file: testbench/dcnc_host.sv
// Two-wire bus host model that drives the serial pins of the core.
// Assumes pull-ups on both lines; sda is the resolved wire level.
`timescale 1ns/100ps
module dcnc_host
(
  input  wire logic   sda_oe,
  output logic        scl,
  output logic        sda,
  output logic        rd_valid,
  output logic [15:0] rd_word
);
  logic sda_low;
  // Released line floats to its pull-up level
  assign sda = !(sda_low || sda_oe);
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
    rd_valid = 1'b0;
    rd_word = 16'h0000;
  end
  // Data changes 60 ns after the clock fall, past the slave hold window
  task automatic put_bit(input logic b);
    #60 sda_low = !b;
    #20 scl = 1'b1;
    #80 scl = 1'b0;
  endtask
  task automatic get_bit(output logic b);
    #60 sda_low = 1'b0;
    #20 scl = 1'b1;
    #40 b = sda;
    #40 scl = 1'b0;
  endtask
  task automatic start_c();
    #60 sda_low = 1'b0;
    #20 scl = 1'b1;
    #40 sda_low = 1'b1;
    #40 scl = 1'b0;
  endtask
  task automatic stop_c();
    #60 sda_low = 1'b1;
    #20 scl = 1'b1;
    #40 sda_low = 1'b0;
    #200;
  endtask
  task automatic send_byte(input logic [7:0] v);
    logic ack;
    for (int i = 7; i >= 0; i--)
      put_bit(v[i]);
    get_bit(ack);
  endtask
  task automatic write_word(input logic [6:0] dev, input logic [7:0] p,
                            input logic [15:0] w);
    start_c();
    send_byte({dev, 1'b0});
    send_byte(p);
    send_byte(w[15:8]);
    send_byte(w[7:0]);
    stop_c();
  endtask
  task automatic read_word(input logic [6:0] dev, input logic [7:0] p);
    logic [15:0] w;
    start_c();
    send_byte({dev, 1'b0});
    send_byte(p);
    start_c();
    send_byte({dev, 1'b1});
    for (int i = 15; i >= 0; i--)
    begin
      get_bit(w[i]);
      if (i % 8 == 0)
        put_bit(i != 8);
    end
    rd_word = w;
    rd_valid = 1'b1;
    #10 rd_valid = 1'b0;
    stop_c();
  endtask
endmodule

// file: testbench/testbench.sv
// Self-checking bench for the converter control core.
// Assumes the host model on the pins and a shortened store time.
`timescale 1ns/100ps
module testbench;
  localparam int         PROG = 3000;
  localparam logic [6:0] DEV  = 7'h48;
  logic        clk_sys, rst_n, rst_nvm_n, corrupt_user, corrupt_trim;
  logic        scl, sda, sda_oe, rd_valid;
  logic        ref_enable, out_hiz, out_load_10k, waveform_go;
  logic        update_busy, memory_op_active;
  logic        user_crc_fault, factory_crc_fault;
  logic [1:0]  gain_select, waveform_select;
  logic [9:0]  dac_code;
  logic [15:0] rd_word, w;
  logic [31:0] seed;
  logic [15:0] exp_q[$];
  int          errors, tests_run, cycles, busy_len, last_len;

  dcnc_core #(.RES(10), .DEV_ADDR(DEV), .PROG_CYC(PROG)) dut_u
  (
    .clk_sys           (clk_sys),
    .rst_n             (rst_n),
    .rst_nvm_n         (rst_nvm_n),
    .scl_in            (scl),
    .sda_in            (sda),
    .sda_out           (),
    .sda_oe            (sda_oe),
    .corrupt_user      (corrupt_user),
    .corrupt_trim      (corrupt_trim),
    .dac_code          (dac_code),
    .ref_enable        (ref_enable),
    .gain_select       (gain_select),
    .out_hiz           (out_hiz),
    .out_load_10k      (out_load_10k),
    .waveform_select   (waveform_select),
    .waveform_go       (waveform_go),
    .update_busy       (update_busy),
    .memory_op_active  (memory_op_active),
    .user_crc_fault    (user_crc_fault),
    .factory_crc_fault (factory_crc_fault)
  );
  dcnc_host host_u
  (
    .sda_oe   (sda_oe),
    .scl      (scl),
    .sda      (sda),
    .rd_valid (rd_valid),
    .rd_word  (rd_word)
  );

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] p, input logic [15:0] v);
    host_u.write_word(DEV, p, v);
  endtask
  task automatic rd(input logic [7:0] p, input logic [15:0] e);
    exp_q.push_back(e);
    host_u.read_word(DEV, p);
  endtask
  // Code register is read only after this, never while memory is busy
  task automatic wait_idle();
    int n;
    n = 0;
    @(posedge clk_sys);
    while (memory_op_active !== 1'b0 && n < 10000)
    begin
      @(posedge clk_sys);
      n++;
    end
    // Step off the edge so the next frame never races the pin sampling
    #1;
    check({15'h0, memory_op_active}, 16'h0000);
  endtask
  task automatic corrupt(input logic u);
    @(posedge clk_sys);
    #1 corrupt_user = u;
    corrupt_trim = !u;
    @(posedge clk_sys);
    #1 corrupt_user = 1'b0;
    corrupt_trim = 1'b0;
  endtask

  // Results are compared in arrival order against the driver's notes
  always @(posedge rd_valid)
    check(rd_word, exp_q.pop_front());

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      errors++;
      stop_test();
    end
    if (memory_op_active === 1'b1)
      busy_len++;
    else if (busy_len != 0)
    begin
      last_len = busy_len;
      busy_len = 0;
    end
  end

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = !clk_sys;
  end

  initial
  begin
    {rst_n, rst_nvm_n, corrupt_user, corrupt_trim} = 4'h0;
    {errors, tests_run, cycles, busy_len, last_len} = '0;
    seed = 32'h000043EC;
    repeat (2) @(posedge clk_sys);
    #1 {rst_n, rst_nvm_n} = 2'b11;
    wait_idle();
    rd(dcnc_pkg::REG_CFG, dcnc_pkg::CFG_RST);
    check({14'h0, out_hiz, ref_enable}, 16'h0002);
    rd(dcnc_pkg::REG_STAT, 16'h0000);
    rd(8'h40, 16'h0000);
    for (int i = 0; i < 3; i++)
    begin
      seed = lfsr_next(seed);
      w = seed[15:0];
      wr(dcnc_pkg::REG_CODE, w);
      check({6'h00, dac_code}, {6'h00, w[11:2]});
      rd(dcnc_pkg::REG_CODE, w & 16'h0FFC);
    end
    wr(dcnc_pkg::REG_CFG, 16'hFFFF);
    rd(dcnc_pkg::REG_CFG, 16'hEFFF);
    for (int g = 0; g < 4; g++)
    begin
      w = 16'((g << 14) | (g << 3) | 4 | g);
      wr(dcnc_pkg::REG_CFG, w);
      check({14'h0, gain_select}, 16'(g));
      check({14'h0, waveform_select}, 16'(g));
      check({14'h0, out_hiz, out_load_10k}, {14'h0, g == 2, w[3]});
      check({15'h0, ref_enable}, 16'h0001);
    end
    wr(dcnc_pkg::REG_MHI, 16'hFFFF);
    rd(dcnc_pkg::REG_MHI, 16'h0FF0);
    wr(dcnc_pkg::REG_MLO, 16'h1234);
    rd(dcnc_pkg::REG_MLO, 16'h0230);
    wr(dcnc_pkg::REG_CODE, 16'h0ABC);
    wr(dcnc_pkg::REG_TRIG, 16'h0010);
    check({15'h0, memory_op_active}, 16'h0001);
    wr(dcnc_pkg::REG_CODE, 16'h0000);
    rd(dcnc_pkg::REG_STAT, 16'h2000);
    wait_idle();
    check(16'((last_len >= PROG) && (last_len <= PROG + 2)), 16'h1);
    rd(dcnc_pkg::REG_CODE, 16'h0ABC);
    wr(dcnc_pkg::REG_CODE, 16'h0444);
    wr(dcnc_pkg::REG_CFG, 16'h0000);
    wr(dcnc_pkg::REG_TRIG, 16'h0020);
    wait_idle();
    rd(dcnc_pkg::REG_CODE, 16'h0ABC);
    rd(dcnc_pkg::REG_CFG, 16'hC01F);
    rd(dcnc_pkg::REG_TRIG, 16'h0000);
    wr(dcnc_pkg::REG_CODE, 16'h0004);
    wr(dcnc_pkg::REG_TRIG, 16'h000A);
    wait_idle();
    rd(dcnc_pkg::REG_CODE, 16'h0ABC);
    check({15'h0, out_load_10k}, 16'h0001);
    wr(dcnc_pkg::REG_TRIG, 16'h0100);
    check({14'h0, waveform_go, update_busy}, 16'h0003);
    rd(dcnc_pkg::REG_STAT, 16'h1000);
    rd(dcnc_pkg::REG_TRIG, 16'h0100);
    // Only the trigger is touched until the run has stopped
    wr(dcnc_pkg::REG_TRIG, 16'h0000);
    check({15'h0, update_busy}, 16'h0000);
    host_u.write_word(7'h49, dcnc_pkg::REG_CODE, 16'h0FFC);
    rd(dcnc_pkg::REG_CODE, 16'h0ABC);
    corrupt(1'b1);
    wr(dcnc_pkg::REG_TRIG, 16'h0020);
    wait_idle();
    check({15'h0, user_crc_fault}, 16'h0001);
    rd(dcnc_pkg::REG_CFG, dcnc_pkg::CFG_RST);
    rd(dcnc_pkg::REG_STAT, 16'h8000);
    wr(dcnc_pkg::REG_CODE, 16'h0100);
    rd(dcnc_pkg::REG_CODE, 16'h0100);
    wr(dcnc_pkg::REG_TRIG, 16'h0010);
    wait_idle();
    wr(dcnc_pkg::REG_TRIG, 16'h0020);
    wait_idle();
    check({15'h0, user_crc_fault}, 16'h0001);
    wr(dcnc_pkg::REG_TRIG, 16'h000A);
    wait_idle();
    check({15'h0, user_crc_fault}, 16'h0000);
    rd(dcnc_pkg::REG_CODE, 16'h0100);
    corrupt(1'b0);
    wr(dcnc_pkg::REG_TRIG, 16'h0020);
    wait_idle();
    check({15'h0, factory_crc_fault}, 16'h0001);
    rd(dcnc_pkg::REG_STAT, 16'h4000);
    rd(dcnc_pkg::REG_CFG, dcnc_pkg::CFG_RST);
    stop_test();
  end
endmodule
